// ### design/isam_addr_match.v
// slave address comparison with don't-care masking and reserved-address filter
`timescale 1ns/1ns
`include "isam_consts.vh"

module isam_addr_match (
   input  wire [7:0]  first_byte,    // first address byte, address in [7:1]
   input  wire [7:0]  second_byte,   // second byte of a ten-bit address
   input  wire        second_valid,  // second_byte holds a received byte
   input  wire [9:0]  own_addr,      // own slave address
   input  wire [9:0]  dont_care,     // addr_dont_care_bits
   input  wire        ten_bit_mode,  // own address is ten bits
   input  wire        promiscuous,   // promiscuous_enable
   input  wire        gc_enable,     // general_call_enable
   output wire        hit_7,         // seven-bit address match
   output wire        hit_10_hi,     // ten-bit upper byte match
   output wire        hit_10,        // full ten-bit match
   output wire        hit_gc         // general call accepted
);
   wire [6:0] a7 = first_byte[7:1];
   wire       reserved;
   wire [9:0] a10;
   wire [9:0] diff10;
   wire [6:0] diff7;

   // ---------------------------------------------------------------
   // reserved addresses
   // ---------------------------------------------------------------
   // reserved never give a seven-bit match; general call 00 is matched separately by hit_gc
   assign reserved = (a7[6:3] == 4'b0000) || (a7[6:2] == 5'b1111_1);

   // ---------------------------------------------------------------
   // masked compare
   // ---------------------------------------------------------------
   // low seven mask bits
   assign diff7 = (a7 ^ own_addr[6:0]) & ~dont_care[6:0];
   assign a10 = {first_byte[2:1], second_byte};
   assign diff10 = (a10 ^ own_addr) & ~dont_care;

   assign hit_7 = !ten_bit_mode && !reserved &&
                  (promiscuous || (diff7 == 7'h00));
   assign hit_10_hi = ten_bit_mode && (first_byte[7:3] == 5'b1111_0) &&
                      (promiscuous || (diff10[9:8] == 2'b00));
   assign hit_10 = hit_10_hi && second_valid &&
                   (promiscuous || (diff10 == 10'h000));
   assign hit_gc = gc_enable && (first_byte == 8'h00);
endmodule

// ### design/isam_consts.vh
// register map, field positions and reset values of the status and address mask block
`ifndef ISAM_CONSTS_VH
`define ISAM_CONSTS_VH

`define ISAM_OFF_STATUS      8'h00
`define ISAM_OFF_MASK        8'h04
`define ISAM_OFF_RXDATA      8'h08
`define ISAM_OFF_TXDATA      8'h0C
`define ISAM_OFF_CONFIG      8'h10
`define ISAM_OFF_EVENTS      8'h14
`define ISAM_OFF_EVMASK      8'h18
`define ISAM_OFF_OWNADDR     8'h1C

`define ISAM_ST_ACK          15
`define ISAM_ST_TRS          14
`define ISAM_ST_BCL          10
`define ISAM_ST_GC           9
`define ISAM_ST_A10          8
`define ISAM_ST_WCOL         7
`define ISAM_ST_OV           6
`define ISAM_ST_DA           5
`define ISAM_ST_STOP         4
`define ISAM_ST_START        3
`define ISAM_ST_RW           2
`define ISAM_ST_RBF          1
`define ISAM_ST_TBF          0

`define ISAM_CFG_PROMISC     0
`define ISAM_CFG_GENERAL_CALL_ENABLE        1
`define ISAM_CFG_A10M        2

`define ISAM_EV_MATCH        0
`define ISAM_EV_RX           1
`define ISAM_EV_BCL          2
`define ISAM_EV_STOP         3
`define ISAM_EV_WCOL         4
`define ISAM_EV_OV           5
`define ISAM_EV_W            6

`define ISAM_STAT_RESET      16'h0000
`define ISAM_MASK_RESET      10'h000
`define ISAM_OWN_RESET       10'h000
`define ISAM_RESP_OKAY       2'b00
`define ISAM_RESP_SLVERR     2'b10

`endif

// ### design/isam_status.v
// status flags, address masking and AXI4-Lite registers of the two-wire controller
// Behaviour
// - ack_result_flag follows each acknowledge slot, one for NACK.
// - master_tx_active set at master transmit start, cleared after slave ack.
// - bus_collision_flag set on collision during master operation; software clears.
// - general_call_seen set on general call match, cleared on Stop.
// - ten_bit_match_flag set on second byte match, cleared on Stop.
// - transmit write while busy is dropped and sets tx_write_collision.
// - rx move onto unread holding byte sets rx_overflow_flag; software clears.
// - data/address bit cleared on address match, set after data byte.
// - stop flag set on Stop, cleared on Start or Repeated Start.
// - start flag set on Start or Repeated Start, cleared on Stop.
// - direction bit captured from slave address byte.
// - rx_holding_full set on holding write, cleared by software read.
// - tx_holding_full set by software write, cleared at transmit end.
// - each mask one makes that address bit don't-care.
// - unused status and mask bits read zero.
// - masking applies only with promiscuous mode off.
// - reserved addresses never match.
// - general call answered only when enabled.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "isam_consts.vh"

module isam_status (
   input  wire        aclk,             // clock, 100 MHz
   input  wire        aresetn,          // synchronous reset, active low
   input  wire [7:0]  s_axi_awaddr,     // write address
   input  wire        s_axi_awvalid,    // write address valid
   output wire        s_axi_awready,    // write address ready
   input  wire [31:0] s_axi_wdata,      // write data
   input  wire [3:0]  s_axi_wstrb,      // write strobes
   input  wire        s_axi_wvalid,     // write data valid
   output wire        s_axi_wready,     // write data ready
   output reg  [1:0]  s_axi_bresp,      // write response
   output reg         s_axi_bvalid,     // write response valid
   input  wire        s_axi_bready,     // write response ready
   input  wire [7:0]  s_axi_araddr,     // read address
   input  wire        s_axi_arvalid,    // read address valid
   output wire        s_axi_arready,    // read address ready
   output reg  [31:0] s_axi_rdata,      // read data
   output reg  [1:0]  s_axi_rresp,      // read response
   output reg         s_axi_rvalid,     // read data valid
   input  wire        s_axi_rready,     // read data ready
   input  wire        bus_start,        // start or repeated start seen, pulse
   input  wire        bus_stop,         // stop seen, pulse
   input  wire        ack_slot_end,     // end of an acknowledge slot, pulse
   input  wire        ack_level,        // sampled ack bit, one is NACK
   input  wire        master_tx_begin,  // master begins a byte transmit, pulse
   input  wire        collision,        // collision during master operation, pulse
   input  wire        addr_byte_done,   // first address byte received, pulse
   input  wire        addr2_byte_done,  // second ten-bit address byte received, pulse
   input  wire        data_byte_done,   // data byte received into shift reg, pulse
   input  wire        tx_done,          // transmission of holding data complete, pulse
   input  wire        module_busy,      // controller busy, level
   input  wire [7:0]  rx_shift_reg,     // received byte
   output reg  [7:0]  tx_holding_reg,   // byte to transmit
   output reg         addr_ack,         // acknowledge this address byte
   output wire        irq               // interrupt, active high level
);
   reg  [15:0] stat;
   reg  [9:0]  addr_dont_care_bits;
   reg  [9:0]  own_addr;
   reg  [2:0]  cfg;
   reg  [6:0]  ev;
   reg  [6:0]  ev_mask;
   reg  [7:0]  rx_holding_reg;
   reg  [7:0]  first_byte;
   reg  [7:0]  second_byte;
   reg         second_valid;
   reg         aw_held;
   reg         w_held;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire        hit_7;
   wire        hit_10_hi;
   wire        hit_10;
   wire        hit_gc;
   wire        wr_fire;
   wire        rd_fire;
   wire        rx_move;
   wire        tx_write;
   wire        rx_read;
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   reg  [6:0]  ev_set;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `ISAM_OFF_STATUS) || (a == `ISAM_OFF_MASK) ||
                     (a == `ISAM_OFF_RXDATA) || (a == `ISAM_OFF_TXDATA) ||
                     (a == `ISAM_OFF_CONFIG) || (a == `ISAM_OFF_EVENTS) ||
                     (a == `ISAM_OFF_EVMASK) || (a == `ISAM_OFF_OWNADDR);
      end
   endfunction

   // ---------------------------------------------------------------
   // address matcher
   // ---------------------------------------------------------------
   isam_addr_match u_match (
      .first_byte   (first_byte),
      .second_byte  (second_byte),
      .second_valid (second_valid),
      .own_addr     (own_addr),
      .dont_care    (addr_dont_care_bits),
      .ten_bit_mode (cfg[`ISAM_CFG_A10M]),
      .promiscuous  (cfg[`ISAM_CFG_PROMISC]),
      .gc_enable    (cfg[`ISAM_CFG_GENERAL_CALL_ENABLE]),
      .hit_7        (hit_7),
      .hit_10_hi    (hit_10_hi),
      .hit_10       (hit_10),
      .hit_gc       (hit_gc)
   );

   // ---------------------------------------------------------------
   // bus slave handshake
   // ---------------------------------------------------------------
   // either channel may arrive first; each is held until both are in
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) &&
                    !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;

   assign tx_write  = wr_fire && (wa == `ISAM_OFF_TXDATA) && ws[0];
   assign rx_read   = rd_fire && (s_axi_araddr == `ISAM_OFF_RXDATA);
   assign rx_move   = data_byte_done;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ISAM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wa) ? `ISAM_RESP_OKAY : `ISAM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always @* begin
      next_rresp = `ISAM_RESP_OKAY;
      case (s_axi_araddr)
         `ISAM_OFF_STATUS:  next_rdata = {16'h0000, stat[15:14], 3'b000, stat[10:0]};
         `ISAM_OFF_MASK:    next_rdata = {22'h00_0000, addr_dont_care_bits};
         `ISAM_OFF_RXDATA:  next_rdata = {24'h00_0000, rx_holding_reg};
         `ISAM_OFF_TXDATA:  next_rdata = {24'h00_0000, tx_holding_reg};
         `ISAM_OFF_CONFIG:  next_rdata = {29'h0000_0000, cfg};
         `ISAM_OFF_EVENTS:  next_rdata = {25'h000_0000, ev};
         `ISAM_OFF_EVMASK:  next_rdata = {25'h000_0000, ev_mask};
         `ISAM_OFF_OWNADDR: next_rdata = {22'h00_0000, own_addr};
         default: begin
            next_rdata = 32'h0000_0000;
            next_rresp = `ISAM_RESP_SLVERR;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ISAM_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         addr_dont_care_bits <= `ISAM_MASK_RESET;
         own_addr            <= `ISAM_OWN_RESET;
         cfg                 <= 3'b000;
         ev_mask             <= 7'h00;
      end else if (wr_fire) begin
         case (wa)
            `ISAM_OFF_MASK: begin
               if (ws[0]) addr_dont_care_bits[7:0] <= wd[7:0];
               if (ws[1]) addr_dont_care_bits[9:8] <= wd[9:8];
            end
            `ISAM_OFF_OWNADDR: begin
               if (ws[0]) own_addr[7:0] <= wd[7:0];
               if (ws[1]) own_addr[9:8] <= wd[9:8];
            end
            `ISAM_OFF_CONFIG: if (ws[0]) cfg <= wd[2:0];
            `ISAM_OFF_EVMASK: if (ws[0]) ev_mask <= wd[6:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // data holding registers and address capture
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_holding_reg <= 8'h00;
         rx_holding_reg <= 8'h00;
         first_byte     <= 8'hFF;
         second_byte    <= 8'h00;
         second_valid   <= 1'b0;
         addr_ack       <= 1'b0;
      end else begin
         if (tx_write && !module_busy)
            tx_holding_reg <= wd[7:0];
         if (rx_move && !stat[`ISAM_ST_RBF])
            rx_holding_reg <= rx_shift_reg;
         if (addr_byte_done) begin
            first_byte   <= rx_shift_reg;
            second_valid <= 1'b0;
         end
         if (addr2_byte_done) begin
            second_byte  <= rx_shift_reg;
            second_valid <= 1'b1;
         end
         addr_ack <= hit_7 || hit_10 || hit_gc || (hit_10_hi && !second_valid);
      end
   end

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   // matches are evaluated one cycle after the byte is captured
   reg addr_chk;
   reg addr2_chk;
   always @(posedge aclk) begin
      if (!aresetn) begin
         stat      <= `ISAM_STAT_RESET;
         addr_chk  <= 1'b0;
         addr2_chk <= 1'b0;
      end else begin
         addr_chk  <= addr_byte_done;
         addr2_chk <= addr2_byte_done;
         if (ack_slot_end)
            stat[`ISAM_ST_ACK] <= ack_level;
         if (master_tx_begin)
            stat[`ISAM_ST_TRS] <= 1'b1;
         else if (ack_slot_end)
            stat[`ISAM_ST_TRS] <= 1'b0;
         if (collision)
            stat[`ISAM_ST_BCL] <= 1'b1;
         else if (wr_fire && wa == `ISAM_OFF_STATUS && ws[1] && !wd[`ISAM_ST_BCL])
            stat[`ISAM_ST_BCL] <= 1'b0;
         if (addr_chk && hit_gc)
            stat[`ISAM_ST_GC] <= 1'b1;
         else if (bus_stop)
            stat[`ISAM_ST_GC] <= 1'b0;
         if (addr2_chk && hit_10)
            stat[`ISAM_ST_A10] <= 1'b1;
         else if (bus_stop)
            stat[`ISAM_ST_A10] <= 1'b0;
         if (tx_write && module_busy)
            stat[`ISAM_ST_WCOL] <= 1'b1;
         else if (wr_fire && wa == `ISAM_OFF_STATUS && ws[0] && !wd[`ISAM_ST_WCOL])
            stat[`ISAM_ST_WCOL] <= 1'b0;
         if (rx_move && stat[`ISAM_ST_RBF])
            stat[`ISAM_ST_OV] <= 1'b1;
         else if (wr_fire && wa == `ISAM_OFF_STATUS && ws[0] && !wd[`ISAM_ST_OV])
            stat[`ISAM_ST_OV] <= 1'b0;
         if (data_byte_done || tx_done)
            stat[`ISAM_ST_DA] <= 1'b1;
         else if ((addr_chk && (hit_7 || hit_gc || hit_10_hi)) || (addr2_chk && hit_10))
            stat[`ISAM_ST_DA] <= 1'b0;
         if (bus_stop) begin
            stat[`ISAM_ST_STOP]  <= 1'b1;
            stat[`ISAM_ST_START] <= 1'b0;
         end else if (bus_start) begin
            stat[`ISAM_ST_STOP]  <= 1'b0;
            stat[`ISAM_ST_START] <= 1'b1;
         end
         if (addr_byte_done)
            stat[`ISAM_ST_RW] <= rx_shift_reg[0];
         // receive full, set wins over read
         if (rx_move)
            stat[`ISAM_ST_RBF] <= 1'b1;
         else if (rx_read)
            stat[`ISAM_ST_RBF] <= 1'b0;
         if (tx_write && !module_busy)
            stat[`ISAM_ST_TBF] <= 1'b1;
         else if (tx_done)
            stat[`ISAM_ST_TBF] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // interrupt events
   // ---------------------------------------------------------------
   always @* begin
      ev_set = 7'h00;
      ev_set[`ISAM_EV_MATCH] = addr_chk && (hit_7 || hit_gc);
      ev_set[`ISAM_EV_RX]    = rx_move;
      ev_set[`ISAM_EV_BCL]   = collision;
      ev_set[`ISAM_EV_STOP]  = bus_stop;
      ev_set[`ISAM_EV_WCOL]  = tx_write && module_busy;
      ev_set[`ISAM_EV_OV]    = rx_move && stat[`ISAM_ST_RBF];
      ev_set[`ISAM_EV_W]     = addr2_chk && hit_10;
   end

   // read of the event register clears it, but a same-cycle event survives
   always @(posedge aclk) begin
      if (!aresetn)
         ev <= 7'h00;
      else if (rd_fire && s_axi_araddr == `ISAM_OFF_EVENTS)
         ev <= ev_set;
      else
         ev <= ev | ev_set;
   end

   assign irq = |(ev & ev_mask);
endmodule

// ### test/isam_bus_peer.sv
// far-side model: bus events as the controller's byte engine reports them
`timescale 1ns/1ns
module isam_bus_peer (
   input  wire       aclk,             // controller clock
   output wire       bus_start,        // start or repeated start
   output wire       bus_stop,         // stop
   output wire       ack_slot_end,     // end of ack slot
   output wire       master_tx_begin,  // master byte begins
   output wire       collision,        // collision seen
   output wire       addr_byte_done,   // address byte in
   output wire       addr2_byte_done,  // second address byte in
   output wire       data_byte_done,   // data byte in
   output wire       tx_done,          // transmit complete
   output reg        ack_level,        // sampled ack, one is nack
   output reg        module_busy,      // controller busy
   output reg  [7:0] rx_shift_reg      // byte off the wire
);
   reg [8:0] ev = 9'h000;
   assign {tx_done, data_byte_done, addr2_byte_done, addr_byte_done, collision,
           master_tx_begin, ack_slot_end, bus_stop, bus_start} = ev;
   initial begin
      ack_level = 1'b1;
      module_busy = 1'b0;
      rx_shift_reg = 8'hff;
   end
   // byte is stale once the pulse ends, so show its inverse
   task fire(input [8:0] e, input [7:0] b, input nk);
      begin
         ev <= e;
         rx_shift_reg <= b;
         ack_level <= nk;
         @(posedge aclk);
         ev <= 9'h000;
         rx_shift_reg <= ~b;
         ack_level <= ~nk;
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule

// ### test/isam_status_asserts.sv
// port assertions for the status and address mask block
`timescale 1ns/1ns
`include "isam_consts.vh"
module isam_status_asserts (
   input wire        aclk,            // clock
   input wire        aresetn,         // sync reset, active low
   input wire [7:0]  s_axi_awaddr,    // write address
   input wire        s_axi_awvalid,   // write address valid
   input wire        s_axi_awready,   // write address ready
   input wire [31:0] s_axi_wdata,     // write data
   input wire [3:0]  s_axi_wstrb,     // write strobes
   input wire        s_axi_wvalid,    // write data valid
   input wire        s_axi_wready,    // write data ready
   input wire [1:0]  s_axi_bresp,     // write response
   input wire        s_axi_bvalid,    // write response valid
   input wire        s_axi_bready,    // write response ready
   input wire        s_axi_arvalid,   // read address valid
   input wire        s_axi_arready,   // read address ready
   input wire [31:0] s_axi_rdata,     // read data
   input wire        s_axi_rvalid,    // read data valid
   input wire        s_axi_rready,    // read data ready
   input wire        addr_byte_done,  // address byte pulse
   input wire [7:0]  rx_shift_reg,    // received byte
   input wire        module_busy,     // controller busy
   input wire [7:0]  tx_holding_reg,  // byte to transmit
   input wire        addr_ack,        // address acknowledge
   input wire        irq              // interrupt
);
   wire       wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire       to_tx = wr_go && s_axi_awaddr == `ISAM_OFF_TXDATA;
   // seven-bit addresses that no mask may open
   wire       rsvd  = (rx_shift_reg[7:4] == 4'h0 && rx_shift_reg[3:1] != 3'h0) ||
                      rx_shift_reg[7:3] == 5'h1f;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !addr_ack && !s_axi_bvalid)
      else $error("outputs not idle after reset");
   a_write_answer: assert property (wr_go |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   a_wresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_ready_while_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_unmapped_error: assert property (wr_go && s_axi_awaddr > `ISAM_OFF_OWNADDR |=>
      s_axi_bresp == `ISAM_RESP_SLVERR) else $error("unmapped write not refused");
   a_tx_busy_drop: assert property (to_tx && module_busy |=> $stable(tx_holding_reg))
      else $error("transmit byte taken while busy");
   a_tx_load_byte: assert property (to_tx && !module_busy && s_axi_wstrb[0] |=>
      tx_holding_reg == $past(s_axi_wdata[7:0])) else $error("transmit byte not loaded");
   a_reserved_nack: assert property (addr_byte_done && rsvd |-> ##2 !addr_ack)
      else $error("reserved address acknowledged");
endmodule

// ### test/isam_status_test.sv
// self-checking bench for the status and address mask block
`timescale 1ns/1ns
`include "isam_consts.vh"
module isam_status_test;
   localparam [8:0] e_start = 9'h001, e_stop = 9'h002, e_ack = 9'h004, e_mtx = 9'h008;
   localparam [8:0] e_col = 9'h010, e_adr = 9'h020, e_adr2 = 9'h040, e_dat = 9'h080, e_txd = 9'h100;
   localparam [7:0] st = `ISAM_OFF_STATUS, mk = `ISAM_OFF_MASK;
   localparam [31:0] z = 32'h0000_0000, o1 = 32'h0000_0001, f = 32'hffff_ffff;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0000_0000;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0]  rx_shift_reg, tx_holding_reg;
   wire        bus_start, bus_stop, ack_slot_end, ack_level, master_tx_begin, collision;
   wire        addr_byte_done, addr2_byte_done, data_byte_done, tx_done, module_busy;
   wire        addr_ack, irq;
   int         n_fail = 0;
   int         n_checks = 0;
   integer     i;

   isam_status uut (.*);
   isam_bus_peer peer (.*);
   always #5 aclk = ~aclk;

   function [31:0] bt(input integer n);
      bt = 32'h0000_0001 << n;
   endfunction
   function [1:0] rsp(input [7:0] a);
      rsp = (a > `ISAM_OFF_OWNADDR) ? `ISAM_RESP_SLVERR : `ISAM_RESP_OKAY;
   endfunction
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         n_checks++;
         if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         chk("bresp", s_axi_bresp, rsp(a));
         s_axi_bready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp, input [31:0] m);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         chk("rdata", s_axi_rdata & m, exp);
         chk("rresp", s_axi_rresp, rsp(a));
         s_axi_rready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task step(input [8:0] e, input [31:0] exp, input [31:0] m, input [7:0] b = 8'h00,
             input nk = 1'b0);
      begin
         peer.fire(e, b, nk);
         rd(st, exp, m);
      end
   endtask
   task adr(input [7:0] b, input [31:0] exp);
      begin
         peer.fire(e_adr, b, 1'b0);
         chk("addr_ack", addr_ack, exp);
      end
   endtask
   task wrap_up;
      begin
         if (n_fail == 0 && n_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask

   initial begin
      #200000;
      n_fail++;
      wrap_up;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(st, z, f);
      wr(mk, f);
      rd(mk, 32'h0000_03ff, f);
      wr(8'h20, z);
      rd(8'h20, z, z);
      step(e_start, bt(3), bt(3) | bt(4));
      step(e_stop, bt(4), bt(3) | bt(4));
      step(e_start, bt(3), bt(3) | bt(4));
      step(e_mtx, bt(14), bt(14));
      step(e_ack, bt(15), bt(15) | bt(14), 8'h00, 1'b1);
      step(e_ack, z, bt(15));
      step(e_col, bt(10), bt(10));
      wr(st, z);
      rd(st, z, bt(10));
      wr(`ISAM_OFF_TXDATA, 32'h0000_005a);
      chk("tx_holding_reg", tx_holding_reg, 32'h0000_005a);
      step(e_txd, z, bt(0));
      peer.module_busy <= 1'b1;
      wr(`ISAM_OFF_TXDATA, 32'h0000_00a5);
      chk("tx_holding_reg", tx_holding_reg, 32'h0000_005a);
      rd(st, bt(7), bt(7) | bt(0));
      peer.module_busy <= 1'b0;
      wr(st, z);
      rd(st, z, bt(7));
      step(e_dat, bt(1) | bt(5), bt(1) | bt(5) | bt(6), 8'h3c);
      step(e_dat, bt(1) | bt(6), bt(1) | bt(6), 8'hc3);
      rd(`ISAM_OFF_RXDATA, 32'h0000_003c, 32'h0000_00ff);
      rd(st, bt(6), bt(6) | bt(1));
      wr(st, z);
      rd(st, z, bt(6));
      wr(`ISAM_OFF_OWNADDR, 32'h0000_0052);
      wr(mk, z);
      step(e_adr, bt(2), bt(2) | bt(5), 8'ha5);
      chk("addr_ack", addr_ack, o1);
      step(e_adr, z, bt(2), 8'ha4);
      for (i = 0; i < 7; i++) begin
         wr(mk, z);
         adr(8'ha4 ^ (8'h02 << i), z);
         wr(mk, bt(i));
         adr(8'ha4 ^ (8'h02 << i), o1);
      end
      step(e_adr, z, bt(9));
      chk("addr_ack", addr_ack, z);
      wr(`ISAM_OFF_CONFIG, 32'h0000_0002);
      step(e_adr, bt(9), bt(9));
      chk("addr_ack", addr_ack, o1);
      step(e_stop, z, bt(9));
      wr(mk, 32'h0000_03ff);
      adr(8'hf8, z);
      adr(8'h02, z);
      adr(8'h08, z);
      wr(mk, z);
      wr(`ISAM_OFF_CONFIG, o1);
      adr(8'h22, o1);
      wr(`ISAM_OFF_CONFIG, 32'h0000_0004);
      wr(`ISAM_OFF_OWNADDR, 32'h0000_02a5);
      adr(8'hf4, o1);
      step(e_adr2, bt(8), bt(8), 8'ha5);
      adr(8'hf0, z);
      wr(mk, 32'h0000_0200);
      adr(8'hf0, o1);
      step(e_stop, z, bt(8));
      rd(`ISAM_OFF_EVENTS, z, z);
      wr(`ISAM_OFF_EVMASK, bt(2));
      chk("irq", irq, z);
      peer.fire(e_col, 8'h00, 1'b0);
      chk("irq", irq, o1);
      rd(`ISAM_OFF_EVENTS, bt(2), bt(2));
      chk("irq", irq, z);
      wr(`ISAM_OFF_EVMASK, z);
      peer.fire(e_col, 8'h00, 1'b0);
      chk("irq", irq, z);
      rd(`ISAM_OFF_EVENTS, bt(2), bt(2));
      wrap_up;
   end
endmodule

bind isam_status isam_status_asserts chk_ports (.*);
